//--- sis_pkg.sv
// package for the shutter interlock supervisor: register map, field layout, timing
package sis_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses on the wishbone slave)
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h8;
  localparam logic [3:0] ADDR_IRQ_EN = 4'hc;
  localparam logic [3:0] ADDR_IRQ_CLR = 4'h4;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  // ctrl
  localparam int CTRL_TEMP_BIT = 0;
  // status
  localparam int ST_OPEN = 0;
  localparam int ST_CLOSED = 1;
  localparam int ST_SHUT_FLT = 2;
  localparam int ST_TEMP_FLT = 3;
  localparam int ST_LASER_EN = 4;
  localparam int ST_SHUT_EN = 5;
  localparam int ST_MOD_EN = 6;
  localparam int ST_STATE_LO = 8;
  // event bits
  localparam int EV_SHUT_FLT = 0;
  localparam int EV_TEMP_FLT = 1;
  localparam int EV_SYS_LOOP_OPEN = 2;
  localparam int EV_SHUT_LOOP_OPEN = 3;
  localparam int EV_WIDTH = 4;

  localparam logic [3:0] EV_RESET = 4'h0;
  localparam logic [3:0] IRQ_EN_RESET = 4'h0;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 25000000;
  localparam int TRAVEL_MS = 100;
  localparam int TRAVEL_CYCLES = (CLK_HZ / 1000) * TRAVEL_MS;
  localparam int CNT_W = 24;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SH_CLOSED = 2'b00,
    SH_OPENING = 2'b01,
    SH_OPEN = 2'b10,
    SH_CLOSING = 2'b11
  } sis_shutter_type;

  typedef struct packed {
    logic shutter_cmd;
    logic pos_open;
    logic pos_closed;
    logic sys_loop;
    logic shut_loop;
    logic temp_alarm;
  } sis_inputs_type;

endpackage : sis_pkg

//--- sis_supervisor.sv
// shutter and interlock supervisor with a wishbone register slave
//
// Summary of operation
// R1 - open status high only when a shutter is fitted and fully open
// R2 - open status held low while any system fault is present
// R3 - shutter command high requests open, low requests closed; drive follows it
// R4 - shutter fault when travel in either direction exceeds allowed time
// R5 - shutter fault when commanded closed yet closed position not sensed
// R6 - shutter fault latches and shuts the system down
// R7 - over-temperature fault when any monitor reports out-of-range temperature
// R8 - over-temperature fault latches and shuts the system down
// R9 - open system loop prevents laser operation, overriding every other input
// R10 - shutter enabled only with shutter loop closed; loop alone never stops system
// R11 - integrator leaves shutter loop open when no shutter is fitted
// R12 - internal laser enable flag from system loop gates all laser operation
// R13 - closed status only when fitted and closed, low during latched faults
// R14 - modulation permitted only while system loop input is asserted
// R15 - travel time is a cycle-count parameter; faults clear only on reset
// R16 - every asynchronous input passes two flip-flops before use
`timescale 1ns/10ps

module sis_supervisor #(
  parameter int TRAVEL_LIMIT = sis_pkg::TRAVEL_CYCLES // R15
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // controller lines
  input wire logic shutter_cmd_i,
  input wire logic sys_loop_i,
  input wire logic shut_loop_i,
  // shutter position sensors and temperature monitors
  input wire logic pos_open_i,
  input wire logic pos_closed_i,
  input wire logic [3:0] temp_alarm_i,
  // shutter drive and laser gating
  output logic shutter_drive_o,
  output logic laser_en_o,
  output logic mod_en_o,
  // status lines
  output logic open_status_o,
  output logic closed_status_o,
  output logic shutter_fault_o,
  output logic temp_fault_o,
  output logic irq_o
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  sis_pkg::sis_inputs_type raw, meta_r, sync_r;

  always_comb begin
    raw.shutter_cmd = shutter_cmd_i;
    raw.pos_open = pos_open_i;
    raw.pos_closed = pos_closed_i;
    raw.sys_loop = sys_loop_i;
    raw.shut_loop = shut_loop_i;
    raw.temp_alarm = |temp_alarm_i; // R7
  end

  // first stage feeds only the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= raw; // R16
      sync_r <= meta_r; // R16
    end
  end

  // ----------------------------------------------------------------
  // enables
  // ----------------------------------------------------------------
  logic shut_flt_r, temp_flt_r;
  logic laser_flag;
  logic sys_fault;
  logic shutter_en;

  assign sys_fault = shut_flt_r | temp_flt_r;
  // system loop overrides everything else
  assign laser_flag = sync_r.sys_loop & ~sys_fault; // R9 R12
  // a shutter loop left open means no shutter is fitted; laser is unaffected
  assign shutter_en = sync_r.shut_loop & ~sys_fault; // R10 R11

  // ----------------------------------------------------------------
  // shutter travel tracking
  // ----------------------------------------------------------------
  sis_pkg::sis_shutter_type sh_r;
  logic [sis_pkg::CNT_W-1:0] travel_r;
  logic travel_timeout;
  logic closed_missing;

  function automatic logic is_moving(input sis_pkg::sis_shutter_type s);
    is_moving = (s == sis_pkg::SH_OPENING) || (s == sis_pkg::SH_CLOSING);
  endfunction : is_moving

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sh_r <= sis_pkg::SH_CLOSED;
    end else if (!shutter_en) begin
      sh_r <= sis_pkg::SH_CLOSED;
    end else begin
      unique case (sh_r)
        sis_pkg::SH_CLOSED: begin
          if (sync_r.shutter_cmd) sh_r <= sis_pkg::SH_OPENING; // R3
        end
        sis_pkg::SH_OPENING: begin
          if (!sync_r.shutter_cmd) sh_r <= sis_pkg::SH_CLOSING;
          else if (sync_r.pos_open && !sync_r.pos_closed) sh_r <= sis_pkg::SH_OPEN;
        end
        sis_pkg::SH_OPEN: begin
          if (!sync_r.shutter_cmd) sh_r <= sis_pkg::SH_CLOSING; // R3
        end
        sis_pkg::SH_CLOSING: begin
          if (sync_r.shutter_cmd) sh_r <= sis_pkg::SH_OPENING;
          else if (sync_r.pos_closed && !sync_r.pos_open) sh_r <= sis_pkg::SH_CLOSED;
        end
      endcase
    end
  end

  // counter restarts on each direction change
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      travel_r <= '0;
    end else if (!is_moving(sh_r) || !shutter_en) begin
      travel_r <= '0;
    end else if ((sh_r == sis_pkg::SH_OPENING) != sync_r.shutter_cmd) begin
      travel_r <= '0;
    end else if (travel_r != TRAVEL_LIMIT[sis_pkg::CNT_W-1:0]) begin
      travel_r <= travel_r + 1'b1;
    end
  end

  assign travel_timeout = is_moving(sh_r) && shutter_en &&
                          (travel_r == TRAVEL_LIMIT[sis_pkg::CNT_W-1:0]); // R4
  // settled in closed state but sensor not showing closed (open, both or neither)
  assign closed_missing = shutter_en && (sh_r == sis_pkg::SH_CLOSED) && !sync_r.shutter_cmd &&
                          !(sync_r.pos_closed && !sync_r.pos_open); // R5

  // ----------------------------------------------------------------
  // latched faults, cleared by reset only
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shut_flt_r <= 1'b0; // R15
    end else if (travel_timeout || closed_missing) begin
      shut_flt_r <= 1'b1; // R6
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      temp_flt_r <= 1'b0;
    end else if (sync_r.temp_alarm) begin
      temp_flt_r <= 1'b1; // R8
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shutter_drive_o <= 1'b0;
      laser_en_o <= 1'b0;
      mod_en_o <= 1'b0;
      open_status_o <= 1'b0;
      closed_status_o <= 1'b0;
      shutter_fault_o <= 1'b0;
      temp_fault_o <= 1'b0;
    end else begin
      shutter_drive_o <= shutter_en & sync_r.shutter_cmd; // R3
      laser_en_o <= laser_flag; // R6 R8 R12
      mod_en_o <= laser_flag & sync_r.sys_loop; // R14
      open_status_o <= shutter_en & sync_r.pos_open & ~sync_r.pos_closed; // R1 R2
      closed_status_o <= shutter_en & sync_r.pos_closed & ~sync_r.pos_open; // R13
      shutter_fault_o <= shut_flt_r; // R6
      temp_fault_o <= temp_flt_r; // R7
    end
  end

  // ----------------------------------------------------------------
  // interrupt events
  // ----------------------------------------------------------------
  logic [sis_pkg::EV_WIDTH-1:0] ev_stat_r, ev_en_r, ev_now, ev_clr;
  logic sys_loop_d_r, shut_loop_d_r;
  logic wr_req, rd_req;

  assign wr_req = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];
  assign rd_req = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sys_loop_d_r <= 1'b0;
      shut_loop_d_r <= 1'b0;
    end else begin
      sys_loop_d_r <= sync_r.sys_loop;
      shut_loop_d_r <= sync_r.shut_loop;
    end
  end

  always_comb begin
    ev_now = '0;
    ev_now[sis_pkg::EV_SHUT_FLT] = (travel_timeout | closed_missing) & ~shut_flt_r;
    ev_now[sis_pkg::EV_TEMP_FLT] = sync_r.temp_alarm & ~temp_flt_r;
    ev_now[sis_pkg::EV_SYS_LOOP_OPEN] = sys_loop_d_r & ~sync_r.sys_loop;
    ev_now[sis_pkg::EV_SHUT_LOOP_OPEN] = shut_loop_d_r & ~sync_r.shut_loop;
    ev_clr = '0;
    if (wr_req && wb_adr_i == sis_pkg::ADDR_IRQ_CLR) ev_clr = wb_dat_i[sis_pkg::EV_WIDTH-1:0];
  end

  // a new event wins over a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) ev_stat_r <= sis_pkg::EV_RESET;
    else ev_stat_r <= (ev_stat_r & ~ev_clr) | ev_now;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) ev_en_r <= sis_pkg::IRQ_EN_RESET;
    else if (wr_req && wb_adr_i == sis_pkg::ADDR_IRQ_EN) ev_en_r <= wb_dat_i[sis_pkg::EV_WIDTH-1:0];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) irq_o <= 1'b0;
    else irq_o <= |(((ev_stat_r & ~ev_clr) | ev_now) & ev_en_r);
  end

  // ----------------------------------------------------------------
  // wishbone slave: one registered ack per request, a cycle after the strobe
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) wb_ack_o <= 1'b0;
    else wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
  end

  // status and irq-clear share an offset: reads give status, writes clear events
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else if (rd_req) begin
      wb_dat_o <= '0;
      unique case (wb_adr_i)
        sis_pkg::ADDR_CTRL: wb_dat_o[sis_pkg::CTRL_TEMP_BIT] <= temp_flt_r;
        sis_pkg::ADDR_STATUS: begin
          wb_dat_o[sis_pkg::ST_OPEN] <= open_status_o;
          wb_dat_o[sis_pkg::ST_CLOSED] <= closed_status_o;
          wb_dat_o[sis_pkg::ST_SHUT_FLT] <= shut_flt_r;
          wb_dat_o[sis_pkg::ST_TEMP_FLT] <= temp_flt_r;
          wb_dat_o[sis_pkg::ST_LASER_EN] <= laser_flag;
          wb_dat_o[sis_pkg::ST_SHUT_EN] <= shutter_en;
          wb_dat_o[sis_pkg::ST_MOD_EN] <= mod_en_o;
          wb_dat_o[sis_pkg::ST_STATE_LO +: 2] <= sh_r;
        end
        sis_pkg::ADDR_IRQ_STAT: wb_dat_o[sis_pkg::EV_WIDTH-1:0] <= ev_stat_r;
        sis_pkg::ADDR_IRQ_EN: wb_dat_o[sis_pkg::EV_WIDTH-1:0] <= ev_en_r;
        default: wb_dat_o <= '0;
      endcase
    end
  end

endmodule : sis_supervisor

//--- sis_supervisor_properties.sv
// checker: port properties of the interlock supervisor
`timescale 1ns/10ps
module sis_props #(
  parameter int TRAVEL_LIMIT = 20
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // loops and monitors
  input wire logic sys_loop_i,
  input wire logic shut_loop_i,
  input wire logic [3:0] temp_alarm_i,
  // drive, gating and status
  input wire logic shutter_drive_o,
  input wire logic laser_en_o,
  input wire logic mod_en_o,
  input wire logic open_status_o,
  input wire logic closed_status_o,
  input wire logic shutter_fault_o,
  input wire logic temp_fault_o
);
  int move_cnt;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // cycles spent opening without arriving; cleared by arrival or by the fault itself
  always_ff @(posedge clk_i) begin
    if (rst_i || !shutter_drive_o || open_status_o || shutter_fault_o) move_cnt <= 0;
    else move_cnt <= move_cnt + 1;
  end
  // five cycles covers the two sync flops plus the output register
  sequence s_loop_only;
    (sys_loop_i && !shut_loop_i && !shutter_fault_o && !temp_fault_o) [*5];
  endsequence
  sequence s_sys_open;
    !sys_loop_i [*4];
  endsequence
  a_shut_sticky: assert property (shutter_fault_o |=> shutter_fault_o)
    else $error("shutter fault released");
  a_temp_sticky: assert property (temp_fault_o |=> temp_fault_o)
    else $error("temperature fault released");
  a_temp_raise: assert property (temp_alarm_i != 4'h0 |-> ##[1:4] temp_fault_o)
    else $error("temperature alarm not latched");
  a_fault_stop: assert property ((shutter_fault_o || temp_fault_o) |=>
    !laser_en_o && !mod_en_o && !open_status_o && !closed_status_o) else $error("fault left system on");
  a_sys_gate: assert property (s_sys_open |-> !laser_en_o && !mod_en_o)
    else $error("laser enabled with loop open");
  a_loop_only: assert property (s_loop_only |-> laser_en_o && mod_en_o)
    else $error("shutter loop stopped system");
  a_travel_bound: assert property (move_cnt <= TRAVEL_LIMIT + 4)
    else $error("travel overran without fault");
  // sensors lag the drive by the two sync flops, so only the arrival edge is tied to the drive level
  a_open_drive: assert property ($rose(open_status_o) |-> shutter_drive_o)
    else $error("open status without open drive");
  a_closed_drive: assert property ($rose(closed_status_o) |-> !shutter_drive_o)
    else $error("closed status while driving open");
endmodule : sis_props

//--- sis_shutter_model.sv
// shutter mechanism model: sensors follow the drive after a travel delay
`timescale 1ns/10ps
module sis_shutter_model (
  // clock and controls
  input wire logic clk_i,
  input wire logic drive_i,
  input wire logic stuck_i,
  input wire logic [3:0] delay_i,
  // position sensors
  output logic pos_open_o,
  output logic pos_closed_o
);
  logic at_open = 1'h0;
  logic [3:0] cnt = 4'h0;
  always @(posedge clk_i) begin
    if (drive_i != at_open) begin
      if (cnt >= delay_i) begin
        at_open <= drive_i;
        cnt <= 4'h0;
      end else cnt <= cnt + 4'h1;
    end
  end
  // in flight or jammed both sensors read low, never the stale end
  assign pos_open_o = !stuck_i && drive_i == at_open && at_open;
  assign pos_closed_o = !stuck_i && drive_i == at_open && !at_open;
endmodule : sis_shutter_model

//--- sis_supervisor_bench.sv
// self-checking bench for the shutter interlock supervisor
`timescale 1ns/10ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_total++; $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
`define WAITF(c) for (int n = 0; (c) !== 1'h1; n++) begin if (n > 60) fail(); @(posedge clk_i); end
module sis_supervisor_bench;
  localparam int TL = 20;
  logic clk_i = 1'h0, rst_i = 1'h1, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0, wb_ack_o;
  logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'hf, temp_alarm_i = 4'h0, dly = 4'h3;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, seed = 32'h17;
  logic shutter_cmd_i = 1'h0, sys_loop_i = 1'h1, shut_loop_i = 1'h1, stuck = 1'h0;
  logic pos_open_i, pos_closed_i, shutter_drive_o, laser_en_o, mod_en_o, open_status_o;
  logic closed_status_o, shutter_fault_o, temp_fault_o, irq_o;
  logic [63:0] q[$], note;
  int err_total = 0, comparisons = 0;
  always #20 clk_i = ~clk_i;
  sis_supervisor #(.TRAVEL_LIMIT(TL)) dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .shutter_cmd_i, .sys_loop_i, .shut_loop_i, .pos_open_i,
    .pos_closed_i, .temp_alarm_i, .shutter_drive_o, .laser_en_o, .mod_en_o, .open_status_o,
    .closed_status_o, .shutter_fault_o, .temp_fault_o, .irq_o);
  sis_shutter_model u_shutter (.clk_i, .drive_i(shutter_drive_o), .stuck_i(stuck), .delay_i(dly),
    .pos_open_o(pos_open_i), .pos_closed_o(pos_closed_i));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  task automatic finish_test();
    if (err_total == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : finish_test
  task automatic fail();
    err_total++;
    finish_test();
  endtask : fail
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'h1 && n < 16);
    if (n >= 16) fail();
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask : wb
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    q.push_back({e, m});
    wb(1'h0, a, 32'h0);
  endtask : rd
  task automatic do_reset();
    rst_i <= 1'h1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'h0;
    repeat (8) @(posedge clk_i);
  endtask : do_reset
  // result watcher: each read answer is matched to the oldest note
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'h1 && wb_we_i === 1'h0) begin
      if (q.size() == 0) fail();
      note = q.pop_front();
      `CHK(wb_dat_o & note[31:0], note[63:32])
    end
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    fail();
  end
  initial begin
    do_reset();
    rd(sis_pkg::ADDR_STATUS, 32'h72, 32'h37f);
    rd(sis_pkg::ADDR_IRQ_EN, {28'h0, sis_pkg::IRQ_EN_RESET}, 32'hf);
    rd(sis_pkg::ADDR_IRQ_STAT, {28'h0, sis_pkg::EV_RESET}, 32'hf);
    rd(4'h2, 32'h0, 32'hffffffff);
    for (int i = 0; i < 2; i++) begin
      seed = xs(seed);
      dly <= 4'h2 + {1'h0, seed[2:0]};
      shutter_cmd_i <= 1'h1;
      `WAITF(open_status_o)
      `CHK(shutter_drive_o, 1'h1)
      rd(sis_pkg::ADDR_STATUS, 32'h271, 32'h37f);
      shutter_cmd_i <= 1'h0;
      `WAITF(closed_status_o)
      rd(sis_pkg::ADDR_STATUS, 32'h72, 32'h37f);
    end
    shut_loop_i <= 1'h0;
    repeat (6) @(posedge clk_i);
    rd(sis_pkg::ADDR_STATUS, 32'h50, 32'h7f);
    rd(sis_pkg::ADDR_IRQ_STAT, 32'h8, 32'h8);
    wb(1'h1, sis_pkg::ADDR_IRQ_CLR, 32'h8);
    rd(sis_pkg::ADDR_IRQ_STAT, 32'h0, 32'h8);
    shut_loop_i <= 1'h1;
    repeat (6) @(posedge clk_i);
    rd(sis_pkg::ADDR_STATUS, 32'h72, 32'h7f);
    shutter_cmd_i <= 1'h1;
    `WAITF(shutter_drive_o)
    stuck <= 1'h1;
    repeat (10) @(posedge clk_i);
    rd(sis_pkg::ADDR_STATUS, 32'h0, 32'h4);
    repeat (TL) @(posedge clk_i);
    rd(sis_pkg::ADDR_STATUS, 32'h4, 32'h7f);
    shutter_cmd_i <= 1'h0;
    stuck <= 1'h0;
    repeat (6) @(posedge clk_i);
    rd(sis_pkg::ADDR_STATUS, 32'h4, 32'h7);
    do_reset();
    rd(sis_pkg::ADDR_STATUS, 32'h72, 32'h7f);
    stuck <= 1'h1;
    repeat (8) @(posedge clk_i);
    rd(sis_pkg::ADDR_STATUS, 32'h4, 32'h7f);
    stuck <= 1'h0;
    do_reset();
    wb(1'h1, sis_pkg::ADDR_IRQ_EN, 32'h2);
    seed = xs(seed);
    temp_alarm_i <= 4'h1 << seed[1:0];
    repeat (6) @(posedge clk_i);
    `CHK(irq_o, 1'h1)
    rd(sis_pkg::ADDR_STATUS, 32'h8, 32'h5c);
    wb(1'h1, sis_pkg::ADDR_IRQ_EN, 32'h0);
    @(posedge clk_i);
    `CHK(irq_o, 1'h0)
    temp_alarm_i <= 4'h0;
    wb(1'h1, sis_pkg::ADDR_IRQ_CLR, 32'h2);
    rd(sis_pkg::ADDR_IRQ_STAT, 32'h0, 32'h2);
    rd(sis_pkg::ADDR_STATUS, 32'h8, 32'h8);
    do_reset();
    sys_loop_i <= 1'h0;
    repeat (6) @(posedge clk_i);
    rd(sis_pkg::ADDR_STATUS, 32'h0, 32'h50);
    rd(sis_pkg::ADDR_IRQ_STAT, 32'h4, 32'h4);
    `CHK(laser_en_o, 1'h0)
    finish_test();
  end
endmodule : sis_supervisor_bench
bind sis_supervisor sis_props #(.TRAVEL_LIMIT(TRAVEL_LIMIT)) u_props (.clk_i, .rst_i, .sys_loop_i,
  .shut_loop_i, .temp_alarm_i, .shutter_drive_o, .laser_en_o, .mod_en_o, .open_status_o,
  .closed_status_o, .shutter_fault_o, .temp_fault_o);
